// ### logic/oscsel_pkg.sv

package oscsel_pkg;

	// ----------------------------------------------------------------
	// register offsets and answers
	// ----------------------------------------------------------------
	localparam logic [11:0] SYS_CTRL_OFFSET  = 12'h000;
	localparam logic [11:0] XTAL_CTRL_OFFSET = 12'h004;
	localparam logic [11:0] PIN_CTRL_OFFSET  = 12'h008;
	localparam logic [11:0] STATUS_OFFSET    = 12'h00C;
	localparam logic [1:0]  RESP_OKAY        = 2'h0;
	localparam logic [1:0]  RESP_SLVERR      = 2'h2;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int unsigned SEL_LSB       = 5;
	localparam int unsigned LOW_SRC_BIT   = 2;
	localparam int unsigned FAST_IDLE_BIT = 1;
	localparam int unsigned SLOW_IDLE_BIT = 0;
	localparam int unsigned QS_BIT        = 2;
	localparam int unsigned READY_BIT     = 1;
	localparam int unsigned EN_BIT        = 0;
	localparam int unsigned PIN_A_BIT     = 0;
	localparam int unsigned PIN_B_BIT     = 1;
	localparam int unsigned ST_LOWSRC_BIT = 3;
	localparam int unsigned ST_RUN_BIT    = 4;
	localparam int unsigned ST_LOCK_BIT   = 5;

	// ----------------------------------------------------------------
	// codes and reset values
	// ----------------------------------------------------------------
	localparam logic [2:0]  SEL_LOW       = 3'h7;
	localparam int unsigned SYS_SRC_COUNT = 8;
	localparam int unsigned DIV_W         = 6;

	typedef struct packed {
		logic [2:0] sel;
		logic       low_src;
		logic       fast_idle;
		logic       slow_idle;
	} oscsel_sys_ctrl_type;

	typedef struct packed {
		logic enable;
		logic quick_start;
	} oscsel_xtal_ctrl_type;

	localparam oscsel_sys_ctrl_type  SYS_CTRL_RESET  = '{sel: 3'h0, low_src: 1'b0, fast_idle: 1'b0, slow_idle: 1'b0};
	localparam oscsel_xtal_ctrl_type XTAL_CTRL_RESET = '{enable: 1'b0, quick_start: 1'b0};
	localparam logic [1:0]           PIN_CTRL_RESET  = 2'h0;

	typedef enum logic [1:0] {XTAL_OFF, XTAL_STARTING, XTAL_READY} oscsel_xtal_state_type;
	typedef enum logic [2:0] {REG_SYS, REG_XTAL, REG_PIN, REG_STAT, REG_NONE} oscsel_reg_type;

endpackage

// ### logic/oscsel_sync.sv
`timescale 1ns/1ps
`default_nettype none
module oscsel_sync #(
	parameter int unsigned WIDTH = 1
) (
	input  wire logic             aclk,
	input  wire logic             aresetn,
	input  wire logic [WIDTH-1:0] d,
	output logic      [WIDTH-1:0] q
);
	logic [WIDTH-1:0] meta_q;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			meta_q <= '0;
			q      <= '0;
		end else begin
			meta_q <= d;
			q      <= meta_q;
		end
	end
endmodule
`default_nettype wire

// ### logic/oscsel_clk_switch.sv
`timescale 1ns/1ps
`default_nettype none
module oscsel_clk_switch #(
	parameter int unsigned N = 2
) (
	input  wire logic                 aclk,
	input  wire logic                 aresetn,
	input  wire logic [N-1:0]         src,
	input  wire logic [$clog2(N)-1:0] sel,
	output logic                      clk_q,
	output logic [$clog2(N)-1:0]      cur_q
);
	logic swap;

	if (N < 2) begin : g_chk
		$error("oscsel_clk_switch needs at least two sources");
	end

	// ----------------------------------------------------------------
	// switch only while old source, new source and output are low
	// ----------------------------------------------------------------
	assign swap = (sel != cur_q) && !clk_q && !src[cur_q] && !src[sel];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cur_q <= '0;
		end else if (swap) begin
			cur_q <= sel;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			clk_q <= 1'b0;
		end else begin
			clk_q <= swap ? 1'b0 : src[cur_q];
		end
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	AST_SWITCH_WHILE_LOW: assert property ($changed(cur_q) |-> !$past(clk_q) && !clk_q)
		else $error("clock source changed during a high phase");
endmodule
`default_nettype wire

// ### logic/oscsel_top.sv
// The AXI4-Lite slave port and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module oscsel_top #(
	parameter int unsigned ADDR_W        = 12,
	parameter int unsigned XTAL_QS_EDGES = 1024,
	parameter int unsigned XTAL_LP_EDGES = 8192
) (
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic [2:0]        s_axi_awprot,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic [2:0]        s_axi_arprot,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	input  wire logic              fast_internal_rc_osc,
	input  wire logic              slow_crystal_osc,
	input  wire logic              slow_internal_rc_osc,
	input  wire logic              cpu_halted,
	output logic                   sys_clk,
	output logic                   wdt_clk,
	output logic                   timebase_clk,
	output logic                   fast_osc_enable,
	output logic                   crystal_osc_enable,
	output logic                   crystal_quick_start,
	output logic                   crystal_pin_a_sel,
	output logic                   crystal_pin_b_sel
);
	localparam int unsigned XW = $clog2(XTAL_LP_EDGES + 1);

	oscsel_pkg::oscsel_sys_ctrl_type   sys_ctrl_q;
	oscsel_pkg::oscsel_xtal_ctrl_type  xtal_ctrl_q;
	oscsel_pkg::oscsel_xtal_state_type xtal_state_q;
	oscsel_pkg::oscsel_reg_type        wr_reg;
	oscsel_pkg::oscsel_reg_type        rd_reg;
	logic [1:0]                        pin_ctrl_q;
	logic [2:0]                        osc_s;
	logic                              fast_prev_q;
	logic                              xtal_prev_q;
	logic [oscsel_pkg::DIV_W-1:0]      div_cnt_q;
	logic [XW-1:0]                     xtal_cnt_q;
	logic [XW-1:0]                     xtal_target_q;
	logic                              xtal_ready;
	logic                              low_src_eff;
	logic                              mode_locked;
	logic                              low_level;
	logic [7:0]                        sys_src;
	logic                              sys_level;
	logic [2:0]                        sys_cur;
	logic                              low_cur;
	logic                              sys_run_q;
	logic                              tb_run_q;
	logic                              wr_go;
	logic                              wr_fire;
	logic                              rd_go;
	logic [31:0]                       status_word;

	if (XTAL_QS_EDGES == 0 || XTAL_LP_EDGES < XTAL_QS_EDGES || ADDR_W < 4) begin : g_chk
		$error("oscsel_top: start-up counts or address width out of range");
	end

	function automatic oscsel_pkg::oscsel_reg_type reg_decode(input logic [ADDR_W-1:0] addr);
		logic [11:0] a;
		a = 12'(addr);
		if (ADDR_W > 12 && (addr >> 12) != '0) begin
			return oscsel_pkg::REG_NONE;
		end
		unique case (a)
			oscsel_pkg::SYS_CTRL_OFFSET:  return oscsel_pkg::REG_SYS;
			oscsel_pkg::XTAL_CTRL_OFFSET: return oscsel_pkg::REG_XTAL;
			oscsel_pkg::PIN_CTRL_OFFSET:  return oscsel_pkg::REG_PIN;
			oscsel_pkg::STATUS_OFFSET:    return oscsel_pkg::REG_STAT;
			default:                      return oscsel_pkg::REG_NONE;
		endcase
	endfunction

	// ----------------------------------------------------------------
	// oscillator inputs
	// ----------------------------------------------------------------
	// three source inputs
	oscsel_sync #(
		.WIDTH(3)
	) u_osc_sync (
		.aclk   (aclk),
		.aresetn(aresetn),
		.d      ({slow_internal_rc_osc, slow_crystal_osc, fast_internal_rc_osc}),
		.q      (osc_s)
	);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			fast_prev_q <= 1'b0;
			xtal_prev_q <= 1'b0;
		end else begin
			fast_prev_q <= osc_s[0];
			xtal_prev_q <= osc_s[1];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			div_cnt_q <= 6'h00;
		end else if (osc_s[0] && !fast_prev_q) begin
			div_cnt_q <= div_cnt_q + 6'h01;
		end
	end

	// ----------------------------------------------------------------
	// crystal start-up
	// ----------------------------------------------------------------
	// count crystal edges before use
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			xtal_state_q  <= oscsel_pkg::XTAL_OFF;
			xtal_cnt_q    <= '0;
			xtal_target_q <= '0;
		end else if (!crystal_osc_enable) begin
			xtal_state_q <= oscsel_pkg::XTAL_OFF;
			xtal_cnt_q   <= '0;
		end else begin
			unique case (xtal_state_q)
				oscsel_pkg::XTAL_OFF: begin
					xtal_target_q <= xtal_ctrl_q.quick_start ? XW'(XTAL_QS_EDGES) : XW'(XTAL_LP_EDGES);
					xtal_state_q  <= oscsel_pkg::XTAL_STARTING;
				end
				oscsel_pkg::XTAL_STARTING: begin
					if (xtal_cnt_q >= xtal_target_q) begin
						xtal_state_q <= oscsel_pkg::XTAL_READY;
					end else if (osc_s[1] && !xtal_prev_q) begin
						xtal_cnt_q <= xtal_cnt_q + XW'(1);
					end
				end
				oscsel_pkg::XTAL_READY: begin
					xtal_state_q <= oscsel_pkg::XTAL_READY;
				end
			endcase
		end
	end

	assign xtal_ready  = (xtal_state_q == oscsel_pkg::XTAL_READY);
	// crystal when bit set and started, else slow RC
	assign low_src_eff = sys_ctrl_q.low_src && xtal_ready;
	// crystal drives system clock: mode frozen
	assign mode_locked = (sys_ctrl_q.sel == oscsel_pkg::SEL_LOW) && low_cur;

	// ----------------------------------------------------------------
	// glitch-free source selection
	// ----------------------------------------------------------------
	// single bit chooses the slow source
	oscsel_clk_switch #(
		.N(2)
	) u_low_switch (
		.aclk   (aclk),
		.aresetn(aresetn),
		.src    ({osc_s[1], osc_s[2]}),
		.sel    (low_src_eff),
		.clk_q  (low_level),
		.cur_q  (low_cur)
	);

	// every select code maps to a live source
	assign sys_src = {low_level, div_cnt_q, osc_s[0]};

	// sources and ratios change only in low phases
	oscsel_clk_switch #(
		.N(oscsel_pkg::SYS_SRC_COUNT)
	) u_sys_switch (
		.aclk   (aclk),
		.aresetn(aresetn),
		.src    (sys_src),
		.sel    (sys_ctrl_q.sel),
		.clk_q  (sys_level),
		.cur_q  (sys_cur)
	);

	// ----------------------------------------------------------------
	// clock outputs and halt gating
	// ----------------------------------------------------------------
	// stop system clock while halted, only in a low phase
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sys_run_q <= 1'b1;
			tb_run_q  <= 1'b1;
		end else begin
			if (!sys_level && !sys_clk) begin
				sys_run_q <= !cpu_halted;
			end
			if (!low_level && !timebase_clk) begin
				tb_run_q <= !cpu_halted || sys_ctrl_q.slow_idle;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sys_clk      <= 1'b0;
			wdt_clk      <= 1'b0;
			timebase_clk <= 1'b0;
		end else begin
			sys_clk      <= sys_level && sys_run_q;
			wdt_clk      <= osc_s[2];
			timebase_clk <= low_level && tb_run_q;
		end
	end

	// crystal runs only with both pins given to it
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			fast_osc_enable     <= 1'b1;
			crystal_osc_enable  <= 1'b0;
			crystal_quick_start <= 1'b0;
			crystal_pin_a_sel   <= 1'b0;
			crystal_pin_b_sel   <= 1'b0;
		end else begin
			fast_osc_enable     <= !cpu_halted || sys_ctrl_q.fast_idle;
			crystal_osc_enable  <= xtal_ctrl_q.enable && pin_ctrl_q[oscsel_pkg::PIN_A_BIT]
				&& pin_ctrl_q[oscsel_pkg::PIN_B_BIT];
			// mode sets drive and start-up edge count, clock used either way
			crystal_quick_start <= xtal_ctrl_q.quick_start;
			crystal_pin_a_sel   <= pin_ctrl_q[oscsel_pkg::PIN_A_BIT];
			crystal_pin_b_sel   <= pin_ctrl_q[oscsel_pkg::PIN_B_BIT];
		end
	end

	// ----------------------------------------------------------------
	// register bus: write
	// ----------------------------------------------------------------
	assign wr_go   = s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
	assign wr_fire = s_axi_awready;
	assign wr_reg  = reg_decode(s_axi_awaddr);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= oscsel_pkg::RESP_OKAY;
		end else begin
			s_axi_awready <= wr_go;
			s_axi_wready  <= wr_go;
			if (wr_fire) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (wr_reg == oscsel_pkg::REG_NONE) ? oscsel_pkg::RESP_SLVERR : oscsel_pkg::RESP_OKAY;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sys_ctrl_q <= oscsel_pkg::SYS_CTRL_RESET;
		end else if (wr_fire && s_axi_wstrb[0] && wr_reg == oscsel_pkg::REG_SYS) begin
			sys_ctrl_q.sel       <= s_axi_wdata[oscsel_pkg::SEL_LSB +: 3];
			sys_ctrl_q.low_src   <= s_axi_wdata[oscsel_pkg::LOW_SRC_BIT];
			sys_ctrl_q.fast_idle <= s_axi_wdata[oscsel_pkg::FAST_IDLE_BIT];
			sys_ctrl_q.slow_idle <= s_axi_wdata[oscsel_pkg::SLOW_IDLE_BIT];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			xtal_ctrl_q <= oscsel_pkg::XTAL_CTRL_RESET;
		end else if (wr_fire && s_axi_wstrb[0] && wr_reg == oscsel_pkg::REG_XTAL) begin
			xtal_ctrl_q.enable <= s_axi_wdata[oscsel_pkg::EN_BIT];
			if (!mode_locked) begin
				xtal_ctrl_q.quick_start <= s_axi_wdata[oscsel_pkg::QS_BIT];
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pin_ctrl_q <= oscsel_pkg::PIN_CTRL_RESET;
		end else if (wr_fire && s_axi_wstrb[0] && wr_reg == oscsel_pkg::REG_PIN) begin
			pin_ctrl_q <= s_axi_wdata[1:0];
		end
	end

	// ----------------------------------------------------------------
	// register bus: read
	// ----------------------------------------------------------------
	assign rd_go  = s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
	assign rd_reg = reg_decode(s_axi_araddr);

	always_comb begin
		status_word = 32'h0000_0000;
		status_word[2:0] = sys_cur;
		status_word[oscsel_pkg::ST_LOWSRC_BIT] = low_cur;
		status_word[oscsel_pkg::ST_RUN_BIT] = sys_run_q;
		status_word[oscsel_pkg::ST_LOCK_BIT] = mode_locked;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= oscsel_pkg::RESP_OKAY;
		end else begin
			s_axi_arready <= rd_go;
			if (s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= oscsel_pkg::RESP_OKAY;
				s_axi_rdata  <= 32'h0000_0000;
				unique case (rd_reg)
					oscsel_pkg::REG_SYS: begin
						s_axi_rdata[oscsel_pkg::SEL_LSB +: 3]       <= sys_ctrl_q.sel;
						s_axi_rdata[oscsel_pkg::LOW_SRC_BIT]       <= sys_ctrl_q.low_src;
						s_axi_rdata[oscsel_pkg::FAST_IDLE_BIT]     <= sys_ctrl_q.fast_idle;
						s_axi_rdata[oscsel_pkg::SLOW_IDLE_BIT]     <= sys_ctrl_q.slow_idle;
					end
					oscsel_pkg::REG_XTAL: begin
						s_axi_rdata[oscsel_pkg::QS_BIT]    <= xtal_ctrl_q.quick_start;
						s_axi_rdata[oscsel_pkg::READY_BIT] <= xtal_ready;
						s_axi_rdata[oscsel_pkg::EN_BIT]    <= xtal_ctrl_q.enable;
					end
					oscsel_pkg::REG_PIN:  s_axi_rdata[1:0] <= pin_ctrl_q;
					oscsel_pkg::REG_STAT: s_axi_rdata <= status_word;
					oscsel_pkg::REG_NONE: s_axi_rresp <= oscsel_pkg::RESP_SLVERR;
				endcase
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_enable_write;
		wr_fire && s_axi_wstrb[0] && wr_reg == oscsel_pkg::REG_XTAL && s_axi_wdata[oscsel_pkg::EN_BIT]
			&& pin_ctrl_q == 2'h3 && !crystal_osc_enable;
	endsequence

	sequence s_starting;
		crystal_osc_enable ##1 xtal_state_q == oscsel_pkg::XTAL_STARTING;
	endsequence

	AST_XTAL_START: assert property (s_enable_write |=> xtal_ctrl_q.enable ##1 s_starting)
		else $error("crystal did not begin start-up after enable");
	AST_XTAL_READY_LATE: assert property ($rose(xtal_ready) |-> $past(xtal_cnt_q) >= $past(xtal_target_q))
		else $error("crystal ready before its start-up count");
	AST_LOW_NEEDS_READY: assert property (low_src_eff |-> xtal_ready && sys_ctrl_q.low_src)
		else $error("crystal used as slow source before ready");
	AST_MODE_FROZEN: assert property (mode_locked && $past(mode_locked) |-> $stable(xtal_ctrl_q.quick_start))
		else $error("crystal mode changed while it drives the system clock");
	AST_QS_WRITE: assert property (wr_fire && s_axi_wstrb[0] && wr_reg == oscsel_pkg::REG_XTAL && !mode_locked
		|=> ##1 crystal_quick_start == $past(s_axi_wdata[oscsel_pkg::QS_BIT], 2))
		else $error("quick-start write not reflected on the mode output");
	AST_SEL_WRITE: assert property (wr_fire && s_axi_wstrb[0] && wr_reg == oscsel_pkg::REG_SYS
		|=> sys_ctrl_q.sel == $past(s_axi_wdata[oscsel_pkg::SEL_LSB +: 3]))
		else $error("system clock select write lost");
	AST_DIVIDER: assert property (osc_s[0] && !fast_prev_q |=> div_cnt_q == $past(div_cnt_q) + 6'h01)
		else $error("fast divider missed an edge");
	AST_HALT_STOPS: assert property (!sys_run_q && !$past(sys_run_q) |-> !sys_clk)
		else $error("system clock running while stopped");
	AST_HALT_CAUSE: assert property ($fell(sys_run_q) |-> $past(cpu_halted))
		else $error("system clock stopped without a halt");
	AST_WDT_CLOCK: assert property (wdt_clk == $past(osc_s[2]))
		else $error("watchdog clock does not follow the slow RC");
	AST_PIN_FREE: assert property (!crystal_pin_a_sel || !crystal_pin_b_sel |-> !crystal_osc_enable)
		else $error("crystal enabled without both pins");
endmodule
`default_nettype wire

// ### test/tb_oscillator_source_select.sv
`timescale 1ns/1ps
`default_nettype none
module tb_oscillator_source_select;
	localparam logic [11:0] SYS = oscsel_pkg::SYS_CTRL_OFFSET;
	localparam logic [11:0] XT  = oscsel_pkg::XTAL_CTRL_OFFSET;
	localparam logic [11:0] PIN = oscsel_pkg::PIN_CTRL_OFFSET;
	logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
	logic        awready, wready, bvalid, arready, rvalid, last;
	logic [11:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [1:0]  bresp, rresp;
	logic        f_osc, x_osc, s_osc, cpu_halted, sys_clk, wdt_clk, tbc, fen, xen, xqs, pa, pb;
	int          n_mismatch, total_checks, fcnt, xcnt, len;

	oscsel_top #(.XTAL_QS_EDGES(4), .XTAL_LP_EDGES(16)) u_dut (
		.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .fast_internal_rc_osc(f_osc), .slow_crystal_osc(x_osc),
		.slow_internal_rc_osc(s_osc), .cpu_halted(cpu_halted), .sys_clk(sys_clk), .wdt_clk(wdt_clk),
		.timebase_clk(tbc), .fast_osc_enable(fen), .crystal_osc_enable(xen), .crystal_quick_start(xqs),
		.crystal_pin_a_sel(pa), .crystal_pin_b_sel(pb)
	);

	always #12.5 aclk = ~aclk;

	// ----------------------------------------------------------------
	// oscillators: fast 10, slow rc 40, crystal 48 cycles; crystal only while enabled
	// ----------------------------------------------------------------
	always @(posedge aclk) begin
		fcnt <= fcnt + 1;
		f_osc <= (fcnt % 10) >= 5;
		s_osc <= (fcnt % 40) >= 20;
		if (xen === 1'b1) xcnt <= xcnt + 1;
		x_osc <= (xcnt % 48) >= 24;
	end

	// shortest legal phase is half the fast period
	always @(posedge aclk) begin
		if (aresetn && sys_clk !== last) check(32'(len >= 5), 32'h0000_0001);
		len <= (sys_clk !== last) ? 1 : len + 1;
		last <= sys_clk;
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic test_done;
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// register bus
	// ----------------------------------------------------------------
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready === 1'b1) awvalid <= 1'b0;
			if (wready === 1'b1) wvalid <= 1'b0;
		end while (awvalid || wvalid || bvalid !== 1'b1);
		bready <= 1'b0;
		// registered outputs settle one edge after the register
		@(posedge aclk);
	endtask

	task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready === 1'b1) arvalid <= 1'b0;
		end while (arvalid || rvalid !== 1'b1);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask

	// cycles from one rising edge of the watched clock to the next
	task automatic rise(input bit w, output int p);
		logic prev;
		p = 0;
		prev = w ? wdt_clk : sys_clk;
		forever begin
			@(posedge aclk);
			p++;
			if (!prev && (w ? wdt_clk : sys_clk)) break;
			prev = w ? wdt_clk : sys_clk;
		end
	endtask

	// the first two edges let a pending switch settle
	task automatic per(input bit w, output int p);
		repeat (3) rise(w, p);
	endtask

	task automatic start(input logic qs, output int t);
		logic [31:0] d;
		logic [1:0]  r;
		wr(XT, 32'({qs, 2'b01}));
		check(32'(xen), 32'h0000_0001);
		check(32'(xqs), 32'(qs));
		rd(XT, d, r);
		check(32'(d[oscsel_pkg::READY_BIT]), 32'h0000_0000);
		t = 0;
		while (d[oscsel_pkg::READY_BIT] !== 1'b1) begin
			rd(XT, d, r);
			t++;
		end
	endtask

	initial begin
		logic [31:0] d;
		logic [1:0]  r;
		int          p, t_lp, t_qs;
		aclk = 0;
		aresetn = 0;
		{awvalid, wvalid, bready, arvalid, rready, cpu_halted} = '0;
		{awaddr, araddr, wdata} = '0;
		{f_osc, x_osc, s_osc, last} = '0;
		{fcnt, xcnt, n_mismatch, total_checks} = '0;
		len = 100;
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		rd(SYS, d, r);
		check(d, 32'h0000_0000);
		rd(12'h010, d, r);
		check(32'(r), 32'(oscsel_pkg::RESP_SLVERR));
		for (int s = 0; s < 7; s++) begin
			wr(SYS, 32'(s) << oscsel_pkg::SEL_LSB);
			per(0, p);
			check(32'(p), 32'(10 << s));
		end
		wr(SYS, 32'h0000_00e0);
		per(0, p);
		check(32'(p), 32'h0000_0028);
		per(1, p);
		check(32'(p), 32'h0000_0028);
		wr(PIN, 32'h0000_0003);
		check(32'({pa, pb}), 32'h0000_0003);
		start(1'b0, t_lp);
		wr(XT, 32'h0000_0000);
		start(1'b1, t_qs);
		check(32'(t_lp > t_qs), 32'h0000_0001);
		wr(SYS, 32'h0000_00e4);
		per(0, p);
		check(32'(p), 32'h0000_0030);
		rd(oscsel_pkg::STATUS_OFFSET, d, r);
		check(32'(d[oscsel_pkg::ST_LOCK_BIT]), 32'h0000_0001);
		wr(XT, 32'h0000_0001);
		check(32'(xqs), 32'h0000_0001);
		wr(SYS, 32'h0000_0000);
		wr(XT, 32'h0000_0001);
		check(32'({xen, xqs}), 32'h0000_0002);
		per(0, p);
		check(32'(p), 32'h0000_000a);
		wr(XT, 32'h0000_0000);
		wr(PIN, 32'h0000_0000);
		check(32'({pa, pb}), 32'h0000_0000);
		wr(SYS, 32'h0000_00e0);
		cpu_halted <= 1'b1;
		repeat (60) @(posedge aclk);
		p = 0;
		t_qs = 0;
		t_lp = 0;
		repeat (200) begin
			@(posedge aclk);
			p += (sys_clk !== 1'b0);
			t_qs += (wdt_clk === 1'b1);
			t_lp += (tbc !== 1'b0);
		end
		check(32'(p), 32'h0000_0000);
		check(32'(t_lp), 32'h0000_0000);
		check(32'(t_qs > 0), 32'h0000_0001);
		check(32'(fen), 32'h0000_0000);
		cpu_halted <= 1'b0;
		per(0, p);
		check(32'(p), 32'h0000_0028);
		test_done;
	end

	initial begin
		repeat (60000) @(posedge aclk);
		n_mismatch++;
		test_done;
	end
endmodule
`default_nettype wire
